// [pss_pkg.sv]
// Package for the power-up strap sampler: strap layout, map, constants.
// Assumes an APB master on pclk and strap pins steady around reset release.
package pss_pkg;
   // ==========================================================
   // Strap layout
   typedef struct packed {
      logic shared_bios_strap;
      logic flash_port_strap;
      logic [1:0] base_select_strap;
   } pss_strap_t;

   localparam int SEL_ALT_BIT = 0;
   localparam int SEL_REG_BIT = 1;

   // ==========================================================
   // Host configuration pair addresses
   localparam logic [15:0] PAIR_DEFAULT = 16'h002e;
   localparam logic [15:0] PAIR_ALT = 16'h004e;
   localparam logic [15:0] PAIR_DATA_STEP = 16'h0001;

   // ==========================================================
   // Register map (byte addresses)
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_BASE_LOW = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_BASE_HIGH = 8'h08;
   localparam logic [7:0] BASE_LOW_RST = 8'h2e;
   localparam logic [7:0] BASE_HIGH_RST = 8'h00;

   // Status fields
   localparam int ST_STRAP_LSB = 0;
   localparam int ST_VALID_BIT = 8;
endpackage

// [pss_strap_sampler.sv]
// Strap sampler: latches straps after power-up reset, decodes host pair.
// Assumes presetn is the standby power-up reset and an APB master.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module pss_strap_sampler (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pss_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pss_pkg::pss_strap_t strap_pins,
   input wire logic host_io_valid,
   input wire logic [15:0] host_io_addr,
   output logic straps_valid,
   output logic shared_bios_en,
   output logic kbs_parallel_mode,
   output logic [15:0] cfg_base_addr,
   output logic cfg_index_hit,
   output logic cfg_data_hit
);
   pss_pkg::pss_strap_t strap_q;
   logic captured_q;
   logic cfg_ready_q;
   logic [7:0] base_low_q;
   logic [7:0] base_high_q;
   logic [15:0] cfg_base_q;
   logic [31:0] prdata_q;
   logic slverr_q;
   logic setup;
   logic wr_acc;

   function automatic logic mapped(input logic [pss_pkg::ADDR_W-1:0] a);
      return a == pss_pkg::OFS_STATUS || a == pss_pkg::OFS_BASE_LOW ||
         a == pss_pkg::OFS_BASE_HIGH;
   endfunction

   // ==========================================================
   // Strap capture, once per reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         captured_q <= 1'b0;
      end else begin
         captured_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_q <= '0;
      end else if (!captured_q) begin
         strap_q <= strap_pins;
      end
   end

   // Pair register settles one edge after capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ready_q <= 1'b0;
      end else begin
         cfg_ready_q <= captured_q;
      end
   end

   assign straps_valid = captured_q;
   assign shared_bios_en = strap_q.shared_bios_strap;
   assign kbs_parallel_mode = strap_q.flash_port_strap;

   // ==========================================================
   // Configuration pair selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_base_q <= pss_pkg::PAIR_DEFAULT;
      end else if (strap_q.base_select_strap[pss_pkg::SEL_REG_BIT]) begin
         cfg_base_q <= {base_high_q, base_low_q};
      end else if (strap_q.base_select_strap[pss_pkg::SEL_ALT_BIT]) begin
         cfg_base_q <= pss_pkg::PAIR_ALT;
      end else begin
         cfg_base_q <= pss_pkg::PAIR_DEFAULT;
      end
   end

   assign cfg_base_addr = cfg_base_q;
   // Decode gated until the selected pair is in place
   assign cfg_index_hit = host_io_valid && cfg_ready_q &&
      host_io_addr == cfg_base_q;
   assign cfg_data_hit = host_io_valid && cfg_ready_q &&
      host_io_addr == 16'(cfg_base_q + pss_pkg::PAIR_DATA_STEP);

   // ==========================================================
   // APB slave, zero wait states
   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = slverr_q && psel && penable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_low_q <= pss_pkg::BASE_LOW_RST;
         base_high_q <= pss_pkg::BASE_HIGH_RST;
      end else if (wr_acc) begin
         if (paddr == pss_pkg::OFS_BASE_LOW) begin
            base_low_q <= pwdata[7:0];
         end
         if (paddr == pss_pkg::OFS_BASE_HIGH) begin
            base_high_q <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
         slverr_q <= 1'b0;
      end else if (setup) begin
         slverr_q <= !mapped(paddr);
         prdata_q <= '0;
         if (!pwrite) begin
            unique case (paddr)
               pss_pkg::OFS_STATUS: begin
                  prdata_q[pss_pkg::ST_STRAP_LSB +:
                     $bits(pss_pkg::pss_strap_t)] <= strap_q;
                  prdata_q[pss_pkg::ST_VALID_BIT] <= captured_q;
               end
               pss_pkg::OFS_BASE_LOW: prdata_q[7:0] <= base_low_q;
               pss_pkg::OFS_BASE_HIGH: prdata_q[7:0] <= base_high_q;
               default: prdata_q <= '0;
            endcase
         end
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_strap_capture: assert property (
      !captured_q |=> captured_q && strap_q == $past(strap_pins))
      else $error("straps not captured at first edge");

   a_strap_hold: assert property (
      captured_q |=> $stable(strap_q) && captured_q)
      else $error("captured straps changed");

   a_share_out: assert property (
      captured_q |-> shared_bios_en == strap_q.shared_bios_strap)
      else $error("shared bios enable wrong");

   a_kbs_mode: assert property (
      captured_q |-> kbs_parallel_mode == strap_q.flash_port_strap)
      else $error("keyboard pin mode wrong");

   a_pair_default: assert property (
      captured_q && strap_q.base_select_strap == 2'b00
      |=> cfg_base_addr == pss_pkg::PAIR_DEFAULT)
      else $error("default pair wrong");

   a_pair_alt: assert property (
      captured_q && strap_q.base_select_strap == 2'b01
      |=> cfg_base_addr == pss_pkg::PAIR_ALT)
      else $error("alternate pair wrong");

   a_pair_reg: assert property (
      strap_q.base_select_strap[pss_pkg::SEL_REG_BIT] ##1
      strap_q.base_select_strap[pss_pkg::SEL_REG_BIT]
      |-> cfg_base_addr == $past({base_high_q, base_low_q}))
      else $error("register pair wrong");

   a_data_hit: assert property (
      cfg_data_hit |->
      host_io_addr == 16'(cfg_base_addr + pss_pkg::PAIR_DATA_STEP))
      else $error("data decode wrong");

   // Decode must stay quiet until the pair is valid
   a_hit_gate: assert property (
      !cfg_ready_q |-> !cfg_index_hit && !cfg_data_hit)
      else $error("host decode before pair ready");

   a_index_hit: assert property (
      host_io_valid && cfg_ready_q && host_io_addr == cfg_base_addr
      |-> cfg_index_hit)
      else $error("index decode missed");

   a_status_read: assert property (
      setup && !pwrite && paddr == pss_pkg::OFS_STATUS
      |=> prdata[pss_pkg::ST_STRAP_LSB +: $bits(pss_pkg::pss_strap_t)]
      == $past(strap_q))
      else $error("status read shows wrong straps");

   // Base register writes feed the register-selected pair
   a_base_low_wr: assert property (
      wr_acc && paddr == pss_pkg::OFS_BASE_LOW
      |=> base_low_q == $past(pwdata[7:0]))
      else $error("low base write lost");

   a_base_high_wr: assert property (
      wr_acc && paddr == pss_pkg::OFS_BASE_HIGH
      |=> base_high_q == $past(pwdata[7:0]))
      else $error("high base write lost");

   a_unmap_err: assert property (
      setup && !mapped(paddr) ##1 psel && penable |-> pslverr)
      else $error("unmapped access not refused");

   c_alt_mode: cover property (captured_q && strap_q.base_select_strap[0]);
   c_reg_mode: cover property (wr_acc ##2 strap_q.base_select_strap[1]);
   c_index_hit: cover property (cfg_index_hit ##1 cfg_data_hit);
   c_default_mode: cover property (
      cfg_ready_q && strap_q.base_select_strap == 2'b00 && cfg_index_hit);
endmodule // pss_strap_sampler

// [pss_strap_board.sv]
// Board model: strap pull-ups per bit, optional later pin disturbance.
// Assumes the bench holds fitted steady around reset release.
`timescale 1ns/1ps
module pss_strap_board (
   input wire logic [3:0] fitted,
   input wire logic disturb,
   output pss_pkg::pss_strap_t strap_pins
);
   // Unfitted pull-up reads low
   assign strap_pins = pss_pkg::pss_strap_t'(disturb ? ~fitted : fitted);
endmodule // pss_strap_board

// [power_up_strap_sampler_tb.sv]
// Bench: strap sweep, pin disturbance, base registers over APB.
// Assumes pss_pkg and pss_strap_board are compiled first.
`timescale 1ns/1ps
module power_up_strap_sampler_tb;
   logic pclk, presetn, psel, penable, pwrite, hv, dis, pready, pslverr, err;
   logic sv, sb, kp, ih, dh;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed, lo, hi;
   logic [15:0] ha, cb;
   logic [3:0] fit;
   pss_pkg::pss_strap_t pins;
   int error_cnt, checks;
   pss_strap_board board (.fitted(fit), .disturb(dis), .strap_pins(pins));
   pss_strap_sampler uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_pins(pins),
      .host_io_valid(hv), .host_io_addr(ha), .straps_valid(sv),
      .shared_bios_en(sb), .kbs_parallel_mode(kp), .cfg_base_addr(cb),
      .cfg_index_hit(ih), .cfg_data_hit(dh));
   // ======================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [15:0] eb(input logic [3:0] f);
      if (f[1])
         return {hi[7:0], lo[7:0]};
      return f[0] ? pss_pkg::PAIR_ALT : pss_pkg::PAIR_DEFAULT;
   endfunction
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [32:0] s, e);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         end_of_test();
      end
      @(posedge pclk);
   endtask
   task automatic chk_out();
      chk("valid", sv, 1);
      chk("share", sb, fit[3]);
      chk("kbs", kp, fit[2]);
      chk("base", cb, eb(fit));
   endtask
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   // ======================================
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, hv, dis, paddr, pwdata, ha} = '0;
      {fit, seed, lo} = {4'h0, 32'h25, 24'h0, pss_pkg::BASE_LOW_RST};
      hi = {24'h0, pss_pkg::BASE_HIGH_RST};
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 16; i++) begin
         presetn <= 1'b1;
         repeat (3) @(posedge pclk);
         chk_out();
         dis <= 1'b1;
         repeat (2) @(posedge pclk);
         chk_out();
         hv <= 1'b1;
         ha <= eb(fit);
         @(posedge pclk);
         chk("idx", {ih, dh}, 2'b10);
         ha <= eb(fit) + 16'h1;
         @(posedge pclk);
         chk("dat", {ih, dh}, 2'b01);
         hv <= 1'b0;
         seed = xs(seed);
         lo = seed & 32'hff;
         hi = (seed >> 8) & 32'hff;
         apb(1, pss_pkg::OFS_BASE_LOW, lo);
         apb(1, pss_pkg::OFS_BASE_HIGH, hi);
         @(posedge pclk);
         chk_out();
         apb(0, pss_pkg::OFS_STATUS, seed);
         chk("status", {err, rd}, {24'h1, 4'h0, fit});
         apb(0, 8'h0c, seed);
         chk("unmap", {err, rd}, {1'b1, 32'h0});
         presetn <= 1'b0;
         dis <= 1'b0;
         fit <= i[3:0] + 4'h1;
         lo = {24'h0, pss_pkg::BASE_LOW_RST};
         hi = {24'h0, pss_pkg::BASE_HIGH_RST};
         @(posedge pclk);
      end
      end_of_test();
   end
endmodule // power_up_strap_sampler_tb
